// file: hw/pwmtw_pkg.sv
// Purpose: Shared constants and types for the two-wire PWM slave.
// Assumes: A 50 MHz system clock samples every pin.
// Notes:   Command codes and the read-back layout are local choices.
package pwmtw_pkg;

    // ****************************************************************
    // Clock and PWM timing
    // ****************************************************************
    localparam int CLK_HZ          = 50_000_000;  // System clock rate.
    localparam int PWM_FREQ_1K_HZ  = 1_000;       // Build variant, 1 kHz.
    localparam int PWM_FREQ_5K_HZ  = 5_000;       // Build variant, 5 kHz.
    localparam int PWM_FREQ_10K_HZ = 10_000;      // Build variant, 10 kHz.
    localparam int PWM_FREQ_25K_HZ = 25_000;      // Build variant, 25 kHz.
    localparam int DUTY_W          = 5;           // Width of the duty setting.
    localparam int PWM_STEPS       = 32;          // Steps of 3.125 percent each.

    // Power-up duty setting, half scale.
    localparam logic [4:0] DUTY_RESET = 5'h10;

    // ****************************************************************
    // Byte framing and field positions
    // ****************************************************************
    localparam logic [3:0] BYTE_BITS     = 4'h8;  // Bits in one byte.
    localparam logic [3:0] BIT_CNT_ZERO  = 4'h0;  // Counter start value.
    localparam logic [3:0] BIT_CNT_ONE   = 4'h1;  // Counter after the first sent bit.
    localparam int         CTRL_TYPE_MSB = 7;     // Device type code, high end.
    localparam int         CTRL_TYPE_LSB = 4;     // Device type code, low end.
    localparam int         CTRL_SEL_MSB  = 3;     // Device select bits, high end.
    localparam int         CTRL_SEL_LSB  = 1;     // Device select bits, low end.
    localparam int         CTRL_RW_BIT   = 0;     // One selects a read.
    localparam int         DATA_CMD_MSB  = 7;     // Command field, high end.
    localparam int         DATA_CMD_LSB  = 5;     // Command field, low end.
    localparam int         DATA_DUTY_MSB = 4;     // Duty field, high end.

    // Command field encodings of a written data byte.
    localparam logic [2:0] CMD_DUTY   = 3'h0;     // Load the duty value.
    localparam logic [2:0] CMD_FULL   = 3'h1;     // Force 100 percent duty.
    localparam logic [2:0] CMD_SHDN   = 3'h2;     // Enter shutdown.
    localparam logic [2:0] CMD_RECALL = 3'h3;     // Leave shutdown.

    // ****************************************************************
    // Slave port states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WACK,
        ST_READ,
        ST_RACK,
        ST_IGNORE
    } pwmtw_state_e;

    // Clock cycles per duty step for a given output frequency.
    function automatic int pwmtw_step_cycles(input int freq_hz);
        pwmtw_step_cycles = CLK_HZ / (freq_hz * PWM_STEPS);
    endfunction

endpackage

// file: hw/pwmtw_pwm_gen.sv
// Purpose: Fixed-frequency 32-step pulse-width generator.
// Assumes: Duty, full-on and shutdown come from the same clock domain.
// Notes:   A new duty value takes effect at once, not at the period end.
module pwmtw_pwm_gen #(
    parameter int STEP_CYCLES = 1562
) (
    // Clock and reset.
    input  wire logic                            clk_in,
    input  wire logic                            rst_n_in,
    // Setting.
    input  wire logic [pwmtw_pkg::DUTY_W-1:0]    duty_in,
    input  wire logic                            full_in,
    input  wire logic                            shdn_in,
    // Output pin.
    output logic                                 pwm_out,
    output logic                                 pwm_oe_out
);
    import pwmtw_pkg::*;

    // ****************************************************************
    // Step timing
    // ****************************************************************
    localparam int PRE_W = $clog2(STEP_CYCLES + 1);          // Prescaler width.
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(STEP_CYCLES - 1);

    logic [PRE_W-1:0]  presc_r;   // Cycles within one step.
    logic [DUTY_W-1:0] step_r;    // Step within one period.
    wire               step_end;  // Last cycle of a step.
    wire               level_nxt; // Output level for the next cycle.

    assign step_end  = (presc_r == PRE_LAST);
    // Step below the setting is high, so zero gives a flat low output.
    assign level_nxt = ~shdn_in & (full_in | (step_r < duty_in)); // [RQ2] [RQ3] [RQ25]

    // The prescaler divides the clock so 32 steps make one period.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            presc_r <= '0;
            step_r  <= '0;
        end else begin
            presc_r <= step_end ? '0 : presc_r + PRE_W'(1); // [RQ4]
            step_r  <= step_end ? step_r + DUTY_W'(1) : step_r; // [RQ4]
        end
    end

    // Outputs are registered; shutdown floats the pin.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwm_out    <= 1'b0;
            pwm_oe_out <= 1'b0;
        end else begin
            pwm_out    <= level_nxt;
            pwm_oe_out <= ~shdn_in; // [RQ24]
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    // A wrap of the step counter happens exactly once per period.
    logic [DUTY_W-1:0] wraps_seen_r; // Helper: step index one cycle back.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wraps_seen_r <= '0;
        end else begin
            wraps_seen_r <= step_r;
        end
    end

    a_full_on_high: assert property (full_in && !shdn_in |=> pwm_out) // [RQ3]
        else $error("Full-on did not hold the output high.");
    a_shdn_float: assert property (shdn_in |=> !pwm_oe_out && !pwm_out) // [RQ24]
        else $error("Shutdown did not float the output.");
    a_zero_duty_low: assert property (duty_in == '0 && !full_in |=> !pwm_out) // [RQ25]
        else $error("Zero duty drove the output high.");
    a_step_advance: assert property ($changed(step_r) |-> step_r == wraps_seen_r + 5'h01
        && $past(step_end)) // [RQ4]
        else $error("Step counter advanced at the wrong time.");

endmodule

// file: hw/pwmtw_top.sv
// Purpose: Two-wire slave port that sets a 5-bit PWM with shutdown.
// Assumes: SCL, SDA and select pins are asynchronous and pass two flops.
// Notes:   Fast-mode SCL is far slower than the 50 MHz sampling clock.
//
// Summary of operation
// [RQ1] Reset loads half-scale duty, 50 percent.
// [RQ2] Five-bit setting drives duty, 0 to 96.88%.
// [RQ3] Full-on command gives 100 percent duty.
// [RQ4] Period fixed per build at four frequencies.
// [RQ5] Transfers framed as control byte, data bytes.
// [RQ6] Master makes clock, START, STOP; device slave.
// [RQ7] Master starts only with both lines high.
// [RQ8] SDA changes while SCL low; else control.
// [RQ9] Detect START and STOP while SCL high.
// [RQ10] Any byte count; ninth clock carries acknowledge.
// [RQ11] Works at standard and fast clock rates.
// [RQ12] Acknowledge held low through whole high phase.
// [RQ13] Master not-acknowledge makes device release SDA.
// [RQ14] Write: control then data; acknowledge every byte.
// [RQ15] Master acknowledges reads except the last.
// [RQ16] Repeated START resynchronises to a new transfer.
// [RQ17] Control byte: type code, select, direction.
// [RQ18] Respond only when select bits match pins.
// [RQ19] Direction one reads, zero writes.
// [RQ20] Acknowledge a matching control byte.
// [RQ21] Read mode shifts data out on SCL.
// [RQ22] Mismatch: no acknowledge, ignore until START.
// [RQ23] Data byte: low five duty, high three command.
// [RQ24] Shutdown floats the PWM output.
// [RQ25] Each step 3.125 percent; zero means 0%.
// [RQ26] All bytes travel most significant bit first.
module pwmtw_top #(
    parameter int         PWM_FREQ_HZ   = pwmtw_pkg::PWM_FREQ_1K_HZ,
    parameter logic [3:0] DEV_TYPE_CODE = 4'hA  // Arbitrary value.
) (
    // Clock and reset.
    input  wire logic                         ref_clk_in,
    input  wire logic                         nrst_in,
    // Two-wire bus, open drain.
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_out,
    // Device select straps.
    input  wire logic                         select_pin_bit0_in,
    input  wire logic                         select_pin_bit1_in,
    input  wire logic                         select_pin_bit2_in,
    // PWM pin.
    output logic                              pwm_out,
    output logic                              pwm_oe_out,
    // Status.
    output logic [pwmtw_pkg::DUTY_W-1:0]      duty_out,
    output logic                              full_on_out,
    output logic                              shutdown_out
);
    import pwmtw_pkg::*;

    // ****************************************************************
    // Reset release and pin synchronisers
    // ****************************************************************
    logic [1:0] rst_sync_r;   // Reset release chain.
    wire        rst_n;        // Synchronised reset, active low.
    wire  [4:0] pins_raw;     // {select[2:0], sda, scl}.
    logic [4:0] pins_s1_r;    // First stage, read only by the second.
    logic [4:0] pins_s2_r;    // Second stage, safe to use.
    logic       scl_d_r;      // SCL one cycle older.
    logic       sda_d_r;      // SDA one cycle older.

    assign rst_n    = rst_sync_r[1];
    assign pins_raw = {select_pin_bit2_in, select_pin_bit1_in, select_pin_bit0_in,
                       sda_in, scl_in};

    // Assert at once, release two edges later.
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end

    // Two flops per pin, then one more for edge finding on the bus lines.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pins_s1_r <= 5'h03;
            pins_s2_r <= 5'h03;
            scl_d_r   <= 1'b1;
            sda_d_r   <= 1'b1;
        end else begin
            pins_s1_r <= pins_raw;
            pins_s2_r <= pins_s1_r; // [RQ11]
            scl_d_r   <= pins_s2_r[0];
            sda_d_r   <= pins_s2_r[1];
        end
    end

    // ****************************************************************
    // Bus event decode
    // ****************************************************************
    wire       scl_s;      // Sampled SCL.
    wire       sda_s;      // Sampled SDA.
    wire [2:0] sel_s;      // Sampled select pins.
    wire       scl_rise;   // SCL went high.
    wire       scl_fall;   // SCL went low.
    wire       start_evt;  // SDA fell with SCL high.
    wire       stop_evt;   // SDA rose with SCL high.

    assign scl_s     = pins_s2_r[0];
    assign sda_s     = pins_s2_r[1];
    assign sel_s     = pins_s2_r[4:2];
    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    // SCL must be high on both samples so a data change near an edge is
    // never mistaken for a bus condition.
    assign start_evt = scl_s & scl_d_r & sda_d_r & ~sda_s; // [RQ8] [RQ9]
    assign stop_evt  = scl_s & scl_d_r & ~sda_d_r & sda_s; // [RQ8] [RQ9]

    // ****************************************************************
    // Slave port state
    // ****************************************************************
    pwmtw_state_e state_r, state_nxt;          // Port state.
    logic [3:0]   bit_cnt_r, bit_cnt_nxt;      // Bits of the current byte.
    logic [7:0]   rx_r, rx_nxt;                // Received byte, MSB first.
    logic [7:0]   tx_r, tx_nxt;                // Byte being sent.
    logic         rw_r, rw_nxt;                // Direction of this transfer.
    logic         nack_r, nack_nxt;            // Master answer to a read byte.
    logic         sda_oe_r, sda_oe_nxt;        // Pull SDA low.
    logic [4:0]   duty_r, duty_nxt;            // Duty setting.
    logic         full_r, full_nxt;            // Full-on in force.
    logic         shdn_r, shdn_nxt;            // Shutdown in force.

    wire       byte_done;  // Eighth bit has ended.
    wire       addr_hit;   // Control byte names this device.
    wire [2:0] wr_cmd;     // Command field of a written byte.
    wire [7:0] rd_byte;    // Byte returned on a read.

    assign byte_done = scl_fall & (bit_cnt_r == BYTE_BITS); // [RQ5] [RQ10]
    assign addr_hit  = (rx_r[CTRL_TYPE_MSB:CTRL_TYPE_LSB] == DEV_TYPE_CODE) // [RQ17]
                     & (rx_r[CTRL_SEL_MSB:CTRL_SEL_LSB] == sel_s); // [RQ18]
    assign wr_cmd    = rx_r[DATA_CMD_MSB:DATA_CMD_LSB]; // [RQ23]
    assign rd_byte   = {shdn_r, full_r, 1'b0, duty_r};

    // Next-state logic. START and STOP override any state, so a repeated
    // START always brings the port back to the control byte.
    always_comb begin
        state_nxt   = state_r;
        bit_cnt_nxt = bit_cnt_r;
        rx_nxt      = rx_r;
        tx_nxt      = tx_r;
        rw_nxt      = rw_r;
        nack_nxt    = nack_r;
        sda_oe_nxt  = sda_oe_r;
        duty_nxt    = duty_r;
        full_nxt    = full_r;
        shdn_nxt    = shdn_r;
        if (start_evt) begin
            state_nxt   = ST_ADDR; // [RQ16]
            bit_cnt_nxt = BIT_CNT_ZERO;
            sda_oe_nxt  = 1'b0;
        end else if (stop_evt) begin
            state_nxt  = ST_IDLE; // [RQ9]
            sda_oe_nxt = 1'b0;
        end else begin
            case (state_r)
                // Shift in on each rising SCL, most significant bit first.
                ST_ADDR, ST_WRITE: begin
                    if (scl_rise && bit_cnt_r != BYTE_BITS) begin
                        rx_nxt      = {rx_r[6:0], sda_s}; // [RQ26]
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end else if (byte_done && state_r == ST_ADDR) begin
                        if (addr_hit) begin
                            sda_oe_nxt = 1'b1; // [RQ20]
                            rw_nxt     = rx_r[CTRL_RW_BIT]; // [RQ19]
                            state_nxt  = ST_ADDR_ACK;
                        end else begin
                            state_nxt = ST_IGNORE; // [RQ22]
                        end
                    end else if (byte_done) begin
                        sda_oe_nxt = 1'b1; // [RQ14]
                        state_nxt  = ST_WACK;
                        case (wr_cmd)
                            CMD_DUTY: begin
                                duty_nxt = rx_r[DATA_DUTY_MSB:0]; // [RQ23]
                                full_nxt = 1'b0;
                            end
                            CMD_FULL:   full_nxt = 1'b1; // [RQ3]
                            CMD_SHDN:   shdn_nxt = 1'b1; // [RQ24]
                            CMD_RECALL: shdn_nxt = 1'b0;
                            default:    shdn_nxt = shdn_r;
                        endcase
                    end
                end
                // Acknowledge is held until SCL falls again.
                ST_ADDR_ACK: begin
                    if (scl_fall && rw_r) begin
                        tx_nxt      = rd_byte; // [RQ21]
                        sda_oe_nxt  = ~rd_byte[7]; // [RQ26]
                        bit_cnt_nxt = BIT_CNT_ONE;
                        state_nxt   = ST_READ;
                    end else if (scl_fall) begin
                        sda_oe_nxt  = 1'b0;
                        bit_cnt_nxt = BIT_CNT_ZERO;
                        state_nxt   = ST_WRITE;
                    end
                end
                ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_nxt  = 1'b0; // [RQ12]
                        bit_cnt_nxt = BIT_CNT_ZERO;
                        state_nxt   = ST_WRITE;
                    end
                end
                // Each falling SCL presents the next bit.
                ST_READ: begin
                    if (scl_fall && bit_cnt_r == BYTE_BITS) begin
                        sda_oe_nxt = 1'b0;
                        state_nxt  = ST_RACK;
                    end else if (scl_fall) begin
                        tx_nxt      = {tx_r[6:0], 1'b0}; // [RQ21]
                        sda_oe_nxt  = ~tx_r[6];
                        bit_cnt_nxt = bit_cnt_r + 4'h1;
                    end
                end
                // The master answers; a high level ends the read.
                ST_RACK: begin
                    if (scl_rise) begin
                        nack_nxt = sda_s;
                    end else if (scl_fall && nack_r) begin
                        state_nxt = ST_IGNORE; // [RQ13]
                    end else if (scl_fall) begin
                        tx_nxt      = rd_byte; // [RQ10]
                        sda_oe_nxt  = ~rd_byte[7];
                        bit_cnt_nxt = BIT_CNT_ONE;
                        state_nxt   = ST_READ;
                    end
                end
                ST_IDLE, ST_IGNORE: begin
                    state_nxt = state_r;
                end
                default: begin
                    state_nxt  = ST_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    // State registers; the duty setting starts at half scale.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= BIT_CNT_ZERO;
            rx_r      <= 8'h00;
            tx_r      <= 8'h00;
            rw_r      <= 1'b0;
            nack_r    <= 1'b0;
            sda_oe_r  <= 1'b0;
            duty_r    <= DUTY_RESET; // [RQ1]
            full_r    <= 1'b0;
            shdn_r    <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            rx_r      <= rx_nxt;
            tx_r      <= tx_nxt;
            rw_r      <= rw_nxt;
            nack_r    <= nack_nxt;
            sda_oe_r  <= sda_oe_nxt;
            duty_r    <= duty_nxt;
            full_r    <= full_nxt;
            shdn_r    <= shdn_nxt;
        end
    end

    // Open drain: the data level is always low, only the enable moves.
    always_ff @(posedge ref_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    assign sda_oe_out   = sda_oe_r;
    assign duty_out     = duty_r;
    assign full_on_out  = full_r;
    assign shutdown_out = shdn_r;

    // ****************************************************************
    // PWM generator
    // ****************************************************************
    pwmtw_pwm_gen #(
        .STEP_CYCLES (pwmtw_step_cycles(PWM_FREQ_HZ))
    ) u_pwm (
        .clk_in     (ref_clk_in),
        .rst_n_in   (rst_n),
        .duty_in    (duty_r),
        .full_in    (full_r),
        .shdn_in    (shdn_r),
        .pwm_out    (pwm_out),
        .pwm_oe_out (pwm_oe_out)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_ctrl_done;
        state_r == ST_ADDR && byte_done;
    endsequence
    sequence s_read_nack;
        state_r == ST_RACK && nack_r && scl_fall;
    endsequence

    a_reset_half: assert property ($rose(rst_n) |-> duty_r == DUTY_RESET) // [RQ1]
        else $error("Duty did not start at half scale.");
    a_start_resync: assert property (start_evt |=> state_r == ST_ADDR
        && bit_cnt_r == BIT_CNT_ZERO && !sda_oe_out) // [RQ16]
        else $error("START did not restart the control byte.");
    a_stop_release: assert property (stop_evt |=> state_r == ST_IDLE && !sda_oe_out) // [RQ9]
        else $error("STOP did not return to idle.");
    a_addr_ack: assert property (s_ctrl_done ##0 addr_hit |=> sda_oe_out
        && rw_r == $past(rx_r[CTRL_RW_BIT])) // [RQ20]
        else $error("Matching control byte not acknowledged.");
    a_addr_miss: assert property (s_ctrl_done ##0 !addr_hit |=> state_r == ST_IGNORE
        && !sda_oe_out) // [RQ22]
        else $error("Mismatched control byte acknowledged.");
    a_ack_held: assert property ((state_r == ST_WACK || state_r == ST_ADDR_ACK)
        && !scl_fall && !start_evt && !stop_evt |=> sda_oe_out) // [RQ12]
        else $error("Acknowledge released too early.");
    a_write_duty: assert property (state_r == ST_WRITE && byte_done && wr_cmd == CMD_DUTY
        |=> duty_r == $past(rx_r[DATA_DUTY_MSB:0]) && !full_r && sda_oe_out) // [RQ23]
        else $error("Written duty value not applied.");
    a_nack_release: assert property (s_read_nack ##0 !start_evt && !stop_evt
        |=> state_r == ST_IGNORE && !sda_oe_out) // [RQ13]
        else $error("Not-acknowledge did not release SDA.");
    a_read_msb: assert property (state_r == ST_ADDR_ACK && scl_fall && rw_r && !start_evt
        |=> sda_oe_out == ~rd_byte[7] && state_r == ST_READ) // [RQ21]
        else $error("Read byte did not start with its top bit.");
    a_sda_scl_low: assert property ($changed(sda_oe_out) && !$past(start_evt)
        && !$past(stop_evt) |-> !scl_s) // [RQ8]
        else $error("SDA changed while SCL was high.");

endmodule

// file: verification/pwmtw_master.sv
// Purpose: Two-wire master model; only it drives SCL.
// Assumes: SDA has a pull-up; any low wins.
// Notes:   SCL phases are four clocks each.
module pwmtw_master (input wire logic clk_in, input wire logic sda_in,
    output logic scl_out = 1'b1, output logic sda_low_out = 1'b0);  // Idle high.
    timeunit 1ns / 1ps;
    task automatic pulse(input logic low, input logic cond, output logic r);
        repeat (2) @(negedge clk_in);
        sda_low_out = low;  // SDA moves with SCL low.
        repeat (2) @(negedge clk_in);
        scl_out = 1'b1;
        repeat (4) @(negedge clk_in);
        r = sda_in;
        if (cond) sda_low_out = ~sda_low_out;
        if (cond) repeat (4) @(negedge clk_in);
        scl_out = cond & ~sda_low_out;  // SCL stays high after STOP.
    endtask
    // MSB first, then the acknowledge clock.
    task automatic xfer(input logic [7:0] w, input logic k, output logic [7:0] r, output logic a);
        for (int i = 7; i >= 0; i--) pulse(~w[i], 1'b0, r[i]);
        pulse(k, 1'b0, a);
        a = ~a;
    endtask
endmodule

// file: verification/tb_top.sv
// Purpose: Self-checking bench for the two-wire PWM slave.
// Assumes: PWM at 250 kHz: 192-clock period, 6-clock steps.
// Notes:   st packs {shutdown, full-on, PWM enable, duty}.
module tb_top;
    timeunit 1ns / 1ps;
    import pwmtw_pkg::*;
    logic       clk = 1'b0, nrst = 1'b0, scl, sda_low, oe, pwm, ack, sdo;
    logic [7:0] rd, hi;
    int         fails = 0, tests_run = 0;
    wire        sda = ~sda_low & (~oe | sdo);  // Pulled up; a driven pin shows sda_out.
    wire  [7:0] st;
    initial forever #10 clk = ~clk;
    pwmtw_top #(.PWM_FREQ_HZ(250_000)) uut (.ref_clk_in(clk), .nrst_in(nrst), .scl_in(scl),
        .sda_in(sda), .sda_out(sdo), .sda_oe_out(oe), .select_pin_bit0_in(1'b1),
        .select_pin_bit1_in(1'b0), .select_pin_bit2_in(1'b1), .pwm_out(pwm),
        .pwm_oe_out(st[5]), .duty_out(st[4:0]), .full_on_out(st[6]), .shutdown_out(st[7]));
    pwmtw_master m (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
    task automatic chk(input logic [7:0] got, exp);
        tests_run++;
        fails += int'(got !== exp);
        if (got !== exp) $display("mismatch at %0t: got %h, want %h", $time, got, exp);
    endtask
    task automatic count_hi(input logic [7:0] exp);  // High clocks per period.
        hi = 8'h00;
        repeat (192) @(negedge clk) hi = hi + {7'h00, pwm};
        chk(hi, exp);
    endtask
    task automatic xb(input logic [7:0] w, exp);
        m.xfer(w, 1'b0, rd, ack);
        chk({7'h00, ack}, exp);
    endtask
    task automatic wr(input logic [7:0] ctl, d, exp);  // START, two bytes, STOP.
        m.pulse(1'b0, 1'b1, ack);
        m.xfer(ctl, 1'b0, rd, hi[0]);
        m.xfer(d, 1'b0, rd, ack);
        m.pulse(1'b1, 1'b1, rd[0]);
        chk({6'h00, hi[0], ack}, exp);
    endtask
    task automatic summarize();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial #400_000 begin  // Far beyond the expected run.
        fails++;
        summarize();
    end
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (8) @(negedge clk);
        chk(st, 8'h30);
        count_hi(8'h60);
        m.pulse(1'b0, 1'b1, ack);
        xb(8'hAA, 8'h01);
        xb({CMD_DUTY, 5'h1F}, 8'h01);
        count_hi(8'hBA);
        wr(8'hAA, {CMD_FULL, 5'h00}, 8'h03);
        wr(8'hAA, {CMD_SHDN, 5'h00}, 8'h03);
        chk(st, 8'hDF);
        m.pulse(1'b0, 1'b1, ack);
        xb(8'hAB, 8'h01);
        m.xfer(8'hFF, 1'b1, rd, ack);
        chk(rd, 8'hDF);
        m.xfer(8'hFF, 1'b0, rd, ack);
        chk({rd[7:1], ack}, 8'hDE);
        wr(8'hAA, {CMD_RECALL, 5'h00}, 8'h03);
        count_hi(8'hC0);
        wr(8'hAA, {CMD_DUTY, 5'h00}, 8'h03);
        count_hi(8'h00);
        wr(8'hA2, {CMD_DUTY, 5'h01}, 8'h00);
        wr(8'h3A, {CMD_DUTY, 5'h02}, 8'h00);
        wr(8'hAA, 8'h9F, 8'h03);
        chk(st, 8'h20);
        summarize();
    end
endmodule
